// *** serial_byte_uart_defines.vh ***
`ifndef SERIAL_BYTE_UART_DEFINES_VH
`define SERIAL_BYTE_UART_DEFINES_VH

// =============================================
// Register indices and address width.
`define REG_IDX_STATUS      16'hC028
`define REG_IDX_BYTE_LOW    16'hC029
`define REG_IDX_BYTE_HIGH   16'hC02A
`define REG_IDX_DIVIDER     16'hC02B
`define ADDR_WIDTH          18

// =============================================
// Status register bit positions.
`define ST_RX_OVERRUN       3
`define ST_RX_DATA_FULL     2
`define ST_TX_HOLDING_FULL  1
`define ST_TX_SHIFTER_ACT   0

// =============================================
// Divider fields and reset value.
`define DIVIDER_FIRST_MSB   15
`define DIVIDER_FIRST_LSB   8
`define DIVIDER_SECOND_MSB  7
`define DIVIDER_SECOND_LSB  0
`define DIVIDER_RESET       16'h0000

// =============================================
// Frame format.
`define FRAME_DATA_BITS     4'h8

`endif

// *** serial_byte_uart.v ***
`timescale 1ns/1ps
`include "serial_byte_uart_defines.vh"

// Overview of operation
// (R01) Idle high; start, eight LSB-first, stop.
// (R02) Status bits: overrun, rx full, tx full, active.
// (R03) Shifter active flag while frame sends.
// (R04) Low data read returns byte, clears full.
// (R05) Low write loads idle shifter, pulses tx_event.
// (R06) Write during frame goes to holding register.
// (R07) Holding empties when moved to shifter.
// (R08) Software writes only when holding is empty.
// (R09) High data register uses bits 15:8.
// (R10) Divider: first 15:8, second 7:0, reset zero.
// (R11) Software keeps second divider 6 to 255.
// (R12) Firmware loads divider before serial use.
// (R13) Bit rate is clock/(first+1)/second.
// (R14) Receiver samples on first stage tick.
// (R15) Idle receiver starts on falling edge.
// (R16) Data bits sampled mid-bit, LSB first.
// (R17) High stop stores byte, sets full, rx_event.
// (R18) Overrun takes previous full on each store.
// (R19) Receiver returns idle after frame.
// (R20) Low stop bit discards the byte.
module serial_byte_uart (
    input  wire        clk,
    input  wire        reset,
    input  wire [17:0] avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire        rx_line,
    output reg         tx_line,
    output reg         tx_event,
    output reg         rx_event
);

    localparam TX_IDLE  = 2'b00;
    localparam TX_START = 2'b01;
    localparam TX_DATA  = 2'b10;
    localparam TX_STOP  = 2'b11;
    localparam RX_IDLE  = 2'b00;
    localparam RX_START = 2'b01;
    localparam RX_DATA  = 2'b10;
    localparam RX_STOP  = 2'b11;

    // =============================================
    // Address decode.
    function is_reg;
        input [17:0] addr;
        input [15:0] idx;
        begin
            is_reg = (addr == {idx, 2'b00});
        end
    endfunction

    reg  [15:0] divider_r;
    reg  [7:0]  rx_data_r;
    reg  [7:0]  tx_hold_r;
    reg         rx_overrun_r;
    reg         rx_data_full_r;
    reg         tx_holding_full_r;
    reg         tx_shifter_active_r;
    reg  [7:0]  first_cnt_r;
    reg  [7:0]  tx_cnt_r;
    reg  [7:0]  tx_shift_r;
    reg  [3:0]  tx_bits_r;
    reg  [1:0]  tx_state_r;
    reg  [7:0]  rx_cnt_r;
    reg  [7:0]  rx_shift_r;
    reg  [3:0]  rx_bits_r;
    reg  [1:0]  rx_state_r;
    reg         rx_prev_r;

    wire [7:0]  first_divider  = divider_r[`DIVIDER_FIRST_MSB:`DIVIDER_FIRST_LSB];
    wire [7:0]  second_divider = divider_r[`DIVIDER_SECOND_MSB:`DIVIDER_SECOND_LSB];
    wire        acc            = (avs_read | avs_write) & avs_waitrequest;
    wire        wr_low         = acc & avs_write & is_reg(avs_address, `REG_IDX_BYTE_LOW);
    wire        wr_high        = acc & avs_write & is_reg(avs_address, `REG_IDX_BYTE_HIGH);
    wire        rd_data        = acc & avs_read & (is_reg(avs_address, `REG_IDX_BYTE_LOW)
                                 | is_reg(avs_address, `REG_IDX_BYTE_HIGH));
    wire        wr_div         = acc & avs_write & is_reg(avs_address, `REG_IDX_DIVIDER);
    wire [7:0]  wr_byte        = wr_high ? avs_writedata[15:8] : avs_writedata[7:0];
    // (R13) First stage tick.
    wire        stage_tick     = (first_cnt_r == first_divider);
    wire        tx_bit_end     = stage_tick & (tx_cnt_r + 8'h01 >= second_divider);
    wire [7:0]  half_bit       = {1'b0, second_divider[7:1]};
    wire        rx_mid         = stage_tick & (rx_cnt_r + 8'h01 >= half_bit);
    wire        rx_bit_end     = stage_tick & (rx_cnt_r + 8'h01 >= second_divider);
    wire        tx_done        = (tx_state_r == TX_STOP) & tx_bit_end;
    wire        tx_free        = ~tx_shifter_active_r | (tx_done & ~tx_holding_full_r);
    wire        tx_load_new    = (wr_low | wr_high) & tx_free;
    wire        tx_load_hold   = tx_done & tx_holding_full_r;
    wire        rx_store       = (rx_state_r == RX_STOP) & rx_mid & rx_line;

    // =============================================
    // Bus slave: one wait cycle, then answer.
    always @(posedge clk) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else begin
            avs_waitrequest <= ~acc;
            if (acc & avs_read) begin
                avs_readdata <= 32'h00000000;
                // (R02) Status bits read.
                if (is_reg(avs_address, `REG_IDX_STATUS))
                    avs_readdata[3:0] <= {rx_overrun_r, rx_data_full_r, tx_holding_full_r, tx_shifter_active_r};
                // (R04) Low byte read.
                if (is_reg(avs_address, `REG_IDX_BYTE_LOW))
                    avs_readdata[7:0] <= rx_data_r;
                // (R09) High byte read.
                if (is_reg(avs_address, `REG_IDX_BYTE_HIGH))
                    avs_readdata[15:8] <= rx_data_r;
                if (is_reg(avs_address, `REG_IDX_DIVIDER))
                    avs_readdata[15:0] <= divider_r;
            end
        end
    end

    // =============================================
    // Divider register and first stage.
    always @(posedge clk) begin
        if (reset) begin
            // (R10) Divider resets zero.
            divider_r   <= `DIVIDER_RESET;
            first_cnt_r <= 8'h00;
        end else begin
            if (wr_div) begin
                if (avs_byteenable[1])
                    divider_r[15:8] <= avs_writedata[15:8];
                if (avs_byteenable[0])
                    divider_r[7:0] <= avs_writedata[7:0];
            end
            first_cnt_r <= stage_tick ? 8'h00 : first_cnt_r + 8'h01;
        end
    end

    // =============================================
    // Transmitter.
    always @(posedge clk) begin
        if (reset) begin
            tx_state_r          <= TX_IDLE;
            tx_line             <= 1'b1;
            tx_event            <= 1'b0;
            tx_shifter_active_r <= 1'b0;
            tx_holding_full_r   <= 1'b0;
            tx_hold_r           <= 8'h00;
            tx_shift_r          <= 8'h00;
            tx_bits_r           <= 4'h0;
            tx_cnt_r            <= 8'h00;
        end else begin
            tx_event <= 1'b0;
            if (stage_tick)
                tx_cnt_r <= tx_bit_end ? 8'h00 : tx_cnt_r + 8'h01;
            if (tx_load_new | tx_load_hold) begin
                // (R05) Load shifter, pulse event.
                tx_shift_r          <= tx_load_new ? wr_byte : tx_hold_r;
                tx_event            <= 1'b1;
                tx_state_r          <= TX_START;
                // (R03) Shifter marked active.
                tx_shifter_active_r <= 1'b1;
                tx_line             <= 1'b0;
                tx_cnt_r            <= 8'h00;
                // (R07) Holding empties on move.
                if (tx_load_hold)
                    tx_holding_full_r <= 1'b0;
            end else if (tx_bit_end) begin
                case (tx_state_r)
                    TX_START: begin
                        tx_state_r <= TX_DATA;
                        tx_line    <= tx_shift_r[0];
                        tx_bits_r  <= 4'h1;
                    end
                    // (R01) LSB first, then stop.
                    TX_DATA: begin
                        if (tx_bits_r == `FRAME_DATA_BITS) begin
                            tx_state_r <= TX_STOP;
                            tx_line    <= 1'b1;
                        end else begin
                            tx_line   <= tx_shift_r[tx_bits_r[2:0]];
                            tx_bits_r <= tx_bits_r + 4'h1;
                        end
                    end
                    TX_STOP: begin
                        tx_state_r          <= TX_IDLE;
                        tx_shifter_active_r <= 1'b0;
                    end
                    default: begin
                        tx_line <= 1'b1;
                    end
                endcase
            end
            // (R06) Hold byte while busy.
            if ((wr_low | wr_high) & ~tx_free) begin
                tx_hold_r         <= wr_byte;
                tx_holding_full_r <= 1'b1;
            end
        end
    end

    // =============================================
    // Receiver.
    always @(posedge clk) begin
        if (reset) begin
            rx_state_r     <= RX_IDLE;
            rx_prev_r      <= 1'b1;
            rx_cnt_r       <= 8'h00;
            rx_shift_r     <= 8'h00;
            rx_bits_r      <= 4'h0;
            rx_data_r      <= 8'h00;
            rx_data_full_r <= 1'b0;
            rx_overrun_r   <= 1'b0;
            rx_event       <= 1'b0;
        end else begin
            rx_event <= 1'b0;
            // (R14) Sampling on first stage tick.
            if (stage_tick) begin
                rx_prev_r <= rx_line;
                rx_cnt_r  <= rx_bit_end ? 8'h00 : rx_cnt_r + 8'h01;
            end
            // (R04) Read clears full.
            if (rd_data)
                rx_data_full_r <= 1'b0;
            case (rx_state_r)
                // (R15) Falling edge starts frame.
                RX_IDLE: begin
                    if (stage_tick & rx_prev_r & ~rx_line) begin
                        rx_state_r <= RX_START;
                        rx_cnt_r   <= 8'h00;
                    end
                end
                RX_START: begin
                    if (rx_bit_end) begin
                        rx_state_r <= RX_DATA;
                        rx_bits_r  <= 4'h0;
                    end
                end
                // (R16) Mid-bit sampling, LSB first.
                RX_DATA: begin
                    if (rx_mid & (rx_cnt_r + 8'h01 == half_bit))
                        rx_shift_r <= {rx_line, rx_shift_r[7:1]};
                    if (rx_bit_end) begin
                        rx_bits_r <= rx_bits_r + 4'h1;
                        if (rx_bits_r == `FRAME_DATA_BITS - 4'h1)
                            rx_state_r <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_mid) begin
                        // (R19) Back to idle; (R20) low stop discards.
                        rx_state_r <= RX_IDLE;
                        rx_prev_r  <= rx_line;
                        if (rx_store) begin
                            // (R17) Store byte, flag, event.
                            rx_data_r      <= rx_shift_r;
                            rx_data_full_r <= 1'b1;
                            rx_event       <= 1'b1;
                            // (R18) Overrun copies previous full.
                            rx_overrun_r   <= rx_data_full_r;
                        end
                    end
                end
                default: begin
                    rx_state_r <= RX_IDLE;
                end
            endcase
        end
    end

endmodule

// *** serial_byte_uart_assertions.sv ***
`timescale 1ns/1ps
module serial_byte_uart_checker (
    input wire        clk,
    input wire        reset,
    input wire [17:0] avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire        tx_line,
    input wire        tx_event,
    input wire        rx_event
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire rd_done = avs_read && !avs_waitrequest;
    // ==========================================
    // Bus, register and line checks.
    ack_one_cycle_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("Bus answer is not one cycle.");
    status_width_a: assert property (rd_done && avs_address == 18'h300A0 |-> avs_readdata[31:4] == 28'h0)
        else $error("Status upper bits set.");
    low_lane_a: assert property (rd_done && avs_address == 18'h300A4 |-> avs_readdata[31:8] == 24'h0)
        else $error("Low data upper bits set.");
    high_lane_a: assert property (rd_done && avs_address == 18'h300A8 |-> avs_readdata[31:16] == 16'h0 && avs_readdata[7:0] == 8'h0)
        else $error("High data outside its lane.");
    divider_width_a: assert property (rd_done && avs_address == 18'h300AC |-> avs_readdata[31:16] == 16'h0)
        else $error("Divider upper bits set.");
    start_bit_min_a: assert property ($fell(tx_line) |-> !tx_line [*6])
        else $error("Start bit too short.");
    tx_start_line_a: assert property (tx_event |-> ##[0:1] !tx_line)
        else $error("No start bit after transmit event.");
    tx_event_pulse_a: assert property (tx_event |=> !tx_event)
        else $error("Transmit event longer than a cycle.");
    rx_event_pulse_a: assert property (rx_event |=> !rx_event)
        else $error("Receive event longer than a cycle.");
    cover property (tx_event);
    cover property (rx_event);
    cover property (rd_done && avs_address == 18'h300A4);
endmodule
bind serial_byte_uart serial_byte_uart_checker serial_byte_uart_checker_inst (
    .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_line(tx_line),
    .tx_event(tx_event), .rx_event(rx_event));

// *** serial_peer_model.sv ***
`timescale 1ns/1ps
module serial_peer_model #(
    parameter BIT = 12
) (
    input  wire clk,
    input  wire tx_line,
    output reg  rx_line
);
    reg [8:0] got_q [$];
    reg [8:0] sh;
    integer   i;
    initial rx_line = 1'b1;
    // ==========================================
    // frame capture, stop bit kept in bit 8.
    always begin
        @(negedge tx_line);
        repeat (BIT / 2) @(posedge clk);
        for (i = 0; i < 9; i = i + 1) begin
            repeat (BIT) @(posedge clk);
            sh = {tx_line, sh[8:1]};
        end
        got_q.push_back(sh);
    end
    // frame drive, idle high after it.
    task send(input [7:0] b, input stop);
        integer k;
        begin
            for (k = 0; k < 10; k = k + 1) begin
                @(posedge clk);
                rx_line <= (k == 0) ? 1'b0 : (k == 9) ? stop : b[k - 1];
                repeat (BIT - 1) @(posedge clk);
            end
            @(posedge clk);
            rx_line <= 1'b1;
            repeat (BIT) @(posedge clk);
        end
    endtask
endmodule

// *** serial_byte_uart_tb.sv ***
`timescale 1ns/1ps
module serial_byte_uart_tb;
    localparam BIT = 12;
    reg         clk = 1'b0;
    reg         reset = 1'b1;
    reg  [17:0] avs_address = 18'h0;
    reg         avs_read = 1'b0;
    reg         avs_write = 1'b0;
    reg  [31:0] avs_writedata = 32'h0;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest;
    wire        rx_line;
    wire        tx_line;
    wire        tx_event;
    wire        rx_event;
    integer     errors = 0;
    integer     checks = 0;
    integer     cycles = 0;
    integer     tx_cnt = 0;
    integer     rx_cnt = 0;
    integer     t;
    reg  [16:0] seed = 17'h12F4E;
    reg  [31:0] q;
    reg  [7:0]  a;
    reg  [7:0]  b;
    always #10 clk = ~clk;
    serial_byte_uart serial_byte_uart_inst (.clk(clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_line(rx_line),
        .tx_line(tx_line), .tx_event(tx_event), .rx_event(rx_event));
    serial_peer_model #(.BIT(BIT)) serial_peer_model_inst (.clk(clk), .tx_line(tx_line), .rx_line(rx_line));
    // ==========================================
    // Event counters and timeout.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (tx_event === 1'b1) tx_cnt <= tx_cnt + 1;
        if (rx_event === 1'b1) rx_cnt <= rx_cnt + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            finish_test;
        end
    end
    function [16:0] lfsr(input [16:0] x);
        lfsr = {x[15:0], x[16] ^ x[13]};
    endfunction
    task rnd(output [7:0] r);
        begin
            repeat (8) seed = lfsr(seed);
            r = seed[7:0];
        end
    endtask
    task bus(input w, input [17:0] ad, input [31:0] d);
        begin
            @(posedge clk);
            avs_address <= ad;
            avs_write <= w;
            avs_read <= !w;
            avs_writedata <= d;
            @(posedge clk);
            while (avs_waitrequest !== 1'b0) @(posedge clk);
            q = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask
    task chk(input [31:0] exp, input [31:0] got);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("[ERR] %0t exp %h got %h", $time, exp, got);
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d errors %0d", checks, errors);
            if (errors == 0 && checks > 0) begin
                $display("TEST PASSED");
            end else begin
                $display("TEST FAILED");
            end
            $finish;
        end
    endtask
    // ==========================================
    // Main sequence.
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        bus(1'b0, 18'h300A0, 32'h0); chk(32'h0, q);
        bus(1'b0, 18'h300AC, 32'h0); chk(32'h0, q);
        bus(1'b0, 18'h300B0, 32'h0); chk(32'h0, q);
        bus(1'b1, 18'h300AC, 32'hFFFF0106);
        bus(1'b0, 18'h300AC, 32'h0); chk(32'h0106, q);
        $display("Reset and divider test done");
        for (t = 0; t < 4; t = t + 1) begin
            rnd(a);
            rnd(b);
            bus(1'b1, 18'h300A4, {24'hA5A5A5, a});
            bus(1'b1, 18'h300A8, {16'h5A5A, b, 8'h3C});
            bus(1'b0, 18'h300A0, 32'h0); chk(32'h3, q);
            repeat (21 * BIT) @(posedge clk);
            chk({23'h0, 1'b1, a}, serial_peer_model_inst.got_q.pop_front());
            chk({23'h0, 1'b1, b}, serial_peer_model_inst.got_q.pop_front());
            bus(1'b0, 18'h300A0, 32'h0); chk(32'h0, q);
            serial_peer_model_inst.send(a, 1'b1);
            bus(1'b0, 18'h300A0, 32'h0); chk(32'h4, q);
            bus(1'b0, 18'h300A4, 32'h0); chk({24'h0, a}, q);
            bus(1'b0, 18'h300A0, 32'h0); chk(32'h0, q);
            serial_peer_model_inst.send(b, 1'b1);
            serial_peer_model_inst.send(a, 1'b1);
            bus(1'b0, 18'h300A0, 32'h0); chk(32'hC, q);
            bus(1'b0, 18'h300A8, 32'h0); chk({16'h0, a, 8'h0}, q);
            serial_peer_model_inst.send(b, 1'b0);
            bus(1'b0, 18'h300A0, 32'h0); chk(32'h8, q);
            serial_peer_model_inst.send(b, 1'b1);
            bus(1'b0, 18'h300A0, 32'h0); chk(32'h4, q);
            bus(1'b0, 18'h300A4, 32'h0); chk({24'h0, b}, q);
            $display("Round %0d done", t);
        end
        chk(32'h8, tx_cnt);
        chk(32'h10, rx_cnt);
        finish_test;
    end
endmodule
